/* design/ddr_bank_table.v */
// Open-row and spacing state for every bank of both ranks
`timescale 1ns/1ps
`include "ddr_dual_rank_defines.vh"

module ddr_bank_table (
   input  wire        i_clk,
   input  wire        i_rst_b,
   input  wire        i_tick,
   input  wire        i_act,
   input  wire        i_pre,
   input  wire        i_pre_all,
   input  wire        i_rank,
   input  wire [3:0]  i_bank,
   input  wire [17:0] i_row,
   output wire        o_open,
   output wire [17:0] o_row,
   output wire        o_rcd_ok,
   output wire        o_rp_ok
);

   localparam integer RCD_I   = `DDR_RCD_CK;
   localparam integer RP_I    = `DDR_RP_CK;
   localparam [4:0]   RCD_CK  = RCD_I[4:0];
   localparam [4:0]   RP_CK   = RP_I[4:0];
   localparam [4:0]   CNT_MAX = 5'h1f;

   wire [4:0]       sel = {i_rank, i_bank};
   // Flat views of the per-bank entries, so each entry has a single driver
   wire [31:0]      open_v;
   wire [32*18-1:0] row_v;
   wire [32*5-1:0]  rcd_v;
   wire [32*5-1:0]  rp_v;

   // ****************************************
   // One entry per bank, all running at once
   // ****************************************
   genvar g;
   generate
      for (g = 0; g < 32; g = g + 1) begin : g_bank
         reg        open_q;
         reg [17:0] row_q;
         reg [4:0]  rcd_q;
         reg [4:0]  rp_q;
         wire       hit = (sel == g);
         wire       pre = i_pre & ((i_pre_all & (i_rank == (g >= 16))) | hit);
         always @(posedge i_clk or negedge i_rst_b) begin
            if (!i_rst_b) begin
               open_q <= 1'b0;
               row_q  <= 18'h0;
               rcd_q  <= 5'h0;
               rp_q   <= CNT_MAX;
            end else if (i_act && hit) begin
               open_q <= 1'b1;
               row_q  <= i_row;
               rcd_q  <= 5'h1;
            end else if (pre) begin
               open_q <= 1'b0;
               rp_q   <= 5'h1;
            end else if (i_tick) begin
               if (rcd_q != CNT_MAX)
                  rcd_q <= rcd_q + 5'h1;
               if (rp_q != CNT_MAX)
                  rp_q <= rp_q + 5'h1;
            end
         end
         assign open_v[g]         = open_q;
         assign row_v[g*18 +: 18] = row_q;
         assign rcd_v[g*5 +: 5]   = rcd_q;
         assign rp_v[g*5 +: 5]    = rp_q;
      end
   endgenerate

   assign o_open   = open_v[sel];
   assign o_row    = row_v[sel*18 +: 18];
   assign o_rcd_ok = (rcd_v[sel*5 +: 5] >= RCD_CK);
   assign o_rp_ok  = (rp_v[sel*5 +: 5] >= RP_CK);

endmodule // ddr_bank_table

/* design/ddr_dual_rank.v */
// Dual-rank memory device: command decode, addressing and data bursts
`timescale 1ns/1ps
`include "ddr_dual_rank_defines.vh"

module ddr_dual_rank #(
   parameter DQ_W     = 8,
   parameter COL_KEEP = 3
) (
   input  wire            i_clk,
   input  wire            i_rst_b,
   input  wire            i_link_clk,
   input  wire [1:0]      i_cs_b,
   input  wire [1:0]      i_cke,
   input  wire [1:0]      i_termination_control,
   input  wire            i_act_b,
   input  wire            i_ras_b,
   input  wire            i_cas_b,
   input  wire            i_we_b,
   input  wire [1:0]      i_bank_group_field,
   input  wire [1:0]      i_bank_field,
   input  wire [17:0]     i_addr,
   input  wire            i_narrow_cfg,
   input  wire            i_burst_interleave,
   input  wire [DQ_W-1:0] i_dq,
   input  wire            i_dqs,
   output reg  [DQ_W-1:0] o_dq,
   output reg             o_dq_oe_b,
   output reg             o_dqs,
   output reg             o_dqs_b,
   output reg             o_dqs_oe_b,
   output reg  [1:0]      o_term_on,
   output reg             o_timing_err,
   output reg             o_protocol_err
);

   localparam IN_W   = 1 + 2 + 2 + 2 + 4 + 4 + 18 + 2 + DQ_W + 1;
   localparam IDX_W  = 1 + 4 + COL_KEEP;
   localparam WORD_W = `DDR_BURST_LEN * DQ_W;
   localparam integer RL_I  = `DDR_RL_CK;
   localparam [4:0]   RL_CK = RL_I[4:0];
   // Link and selects rest high (no false command); enables and termination low
   localparam [IN_W-1:0] SYNC_RST = {3'h7, 4'h0, {(IN_W-7){1'b1}}};

   // ****************************************
   // Two-stage synchronisers on every pin
   // ****************************************
   wire [IN_W-1:0] pins = {i_link_clk, i_cs_b, i_cke, i_termination_control,
                           i_act_b, i_ras_b, i_cas_b, i_we_b,
                           i_bank_group_field, i_bank_field, i_addr,
                           i_narrow_cfg, i_burst_interleave, i_dq, i_dqs};
   reg  [IN_W-1:0] meta_q;
   reg  [IN_W-1:0] sync_q;
   reg             link_prev_q;
   reg             dqs_prev_q;

   always @(posedge i_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         meta_q      <= SYNC_RST;
         sync_q      <= SYNC_RST;
         link_prev_q <= 1'b1;
         dqs_prev_q  <= 1'b1;
      end else begin
         meta_q      <= pins;
         sync_q      <= meta_q;
         link_prev_q <= sync_q[IN_W-1];
         dqs_prev_q  <= sync_q[0];
      end
   end

   wire            link_s = sync_q[IN_W-1];
   wire [1:0]      cs_b   = sync_q[IN_W-2 -: 2];
   wire [1:0]      cke    = sync_q[IN_W-4 -: 2];
   wire [1:0]      termination_control    = sync_q[IN_W-6 -: 2];
   wire            act_b  = sync_q[IN_W-8];
   wire [2:0]      op     = sync_q[IN_W-9 -: 3];
   wire [3:0]      bank   = sync_q[IN_W-12 -: 4];
   wire [17:0]     addr   = sync_q[IN_W-16 -: 18];
   wire            narrow = sync_q[DQ_W+2];
   wire            intlv  = sync_q[DQ_W+1];
   wire [DQ_W-1:0] dq_s   = sync_q[DQ_W:1];
   wire            dqs_s  = sync_q[0];

   wire link_rise = link_s & ~link_prev_q;
   wire link_edge = link_s ^ link_prev_q;
   wire dqs_edge  = dqs_s ^ dqs_prev_q;

   // ****************************************
   // Command decode on link rising edge
   // ****************************************
   wire [1:0] sel   = ~cs_b & cke;
   wire       one   = ^sel;
   wire       rank  = sel[1];
   wire       valid = link_rise & one;
   wire       c_act = valid & ~act_b;
   wire       c_pre = valid & act_b & (op == `DDR_OP_PRE);
   wire       c_rd  = valid & act_b & (op == `DDR_OP_RD);
   wire       c_wr  = valid & act_b & (op == `DDR_OP_WR);
   wire [17:0] row  = narrow ? {1'b0, addr[16:0]} : addr;
   wire [9:0]  col  = addr[9:0];

   wire        b_open;
   wire        b_rcd_ok;
   wire        b_rp_ok;

   ddr_bank_table u_banks (
      .i_clk     (i_clk),
      .i_rst_b   (i_rst_b),
      .i_tick    (link_rise),
      .i_act     (c_act),
      .i_pre     (c_pre),
      .i_pre_all (addr[`DDR_PRE_ALL_BIT]),
      .i_rank    (rank),
      .i_bank    (bank),
      .i_row     (row),
      .o_open    (b_open),
      .o_row     (),
      .o_rcd_ok  (b_rcd_ok),
      .o_rp_ok   (b_rp_ok)
   );

   // ****************************************
   // Core array, one 8n-bit word per access
   // ****************************************
   reg  [WORD_W-1:0] mem [0:(1<<IDX_W)-1];
   wire [IDX_W-1:0]  idx = {rank, bank, col[COL_KEEP+2:3]};

   reg  [2:0]        start_q;
   reg               order_q;
   reg  [IDX_W-1:0]  wr_idx_q;
   reg  [WORD_W-1:0] wr_word_q;
   reg               wr_act_q;
   reg               wr_commit_q;
   reg  [2:0]        wr_beat_q;
   reg  [WORD_W-1:0] rd_word_q;
   reg               rd_wait_q;
   reg  [4:0]        rd_cnt_q;
   reg               rd_run_q;
   reg  [3:0]        rd_beat_q;

   // Burst position for beat k, wrapping inside the 8-word block
   function [2:0] beat_pos;
      input [2:0] start;
      input       ilv;
      input [2:0] k;
      begin
         beat_pos = ilv ? (start ^ k) : (start + k);
      end
   endfunction

   wire [2:0] wr_pos = beat_pos(start_q, order_q, wr_beat_q);
   wire [2:0] rd_pos = beat_pos(start_q, order_q, rd_beat_q[2:0]);

   always @(posedge i_clk) begin
      if (wr_commit_q)
         mem[wr_idx_q] <= wr_word_q;
   end

   // ****************************************
   // Errors and termination
   // ****************************************
   always @(posedge i_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         o_term_on      <= 2'h0;
         o_timing_err   <= 1'b0;
         o_protocol_err <= 1'b0;
      end else begin
         o_term_on      <= termination_control & cke;
         o_timing_err   <= (c_act & ~b_rp_ok) | ((c_rd | c_wr) & ~b_rcd_ok);
         // Access to a closed bank, activate to an open bank, or two selects at once
         o_protocol_err <= ((c_rd | c_wr) & ~b_open) | (c_act & b_open)
                           | (link_rise & (sel == 2'h3));
      end
   end

   // ****************************************
   // Write capture on strobe edges
   // ****************************************
   always @(posedge i_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         start_q     <= 3'h0;
         order_q     <= 1'b0;
         wr_idx_q    <= {IDX_W{1'b0}};
         wr_word_q   <= {WORD_W{1'b0}};
         wr_act_q    <= 1'b0;
         wr_commit_q <= 1'b0;
         wr_beat_q   <= 3'h0;
         rd_word_q   <= {WORD_W{1'b0}};
         rd_wait_q   <= 1'b0;
         rd_cnt_q    <= 5'h0;
      end else begin
         wr_commit_q <= 1'b0;
         // One burst in flight; a new access restarts the slot
         if ((c_wr | c_rd) && b_open) begin
            start_q   <= col[2:0];
            order_q   <= intlv;
            wr_act_q  <= c_wr;
            wr_idx_q  <= idx;
            wr_beat_q <= 3'h0;
            wr_word_q <= mem[idx];
            rd_word_q <= mem[idx];
            rd_wait_q <= c_rd;
            rd_cnt_q  <= 5'h1;
         end else begin
            if (wr_act_q && dqs_edge) begin
               wr_word_q[wr_pos*DQ_W +: DQ_W] <= dq_s;
               wr_beat_q <= wr_beat_q + 3'h1;
               if (wr_beat_q == 3'h7) begin
                  wr_act_q    <= 1'b0;
                  wr_commit_q <= 1'b1;
               end
            end
            if (rd_wait_q && link_rise) begin
               rd_cnt_q <= rd_cnt_q + 5'h1;
               if (rd_cnt_q == RL_CK)
                  rd_wait_q <= 1'b0;
            end
         end
      end
   end

   // ****************************************
   // Read burst: beat and strobe on each link edge
   // ****************************************
   wire rd_go = rd_wait_q & link_rise & (rd_cnt_q == RL_CK);

   always @(posedge i_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         rd_run_q   <= 1'b0;
         rd_beat_q  <= 4'h0;
         o_dq       <= {DQ_W{1'b0}};
         o_dq_oe_b  <= 1'b1;
         o_dqs      <= 1'b0;
         o_dqs_b    <= 1'b1;
         o_dqs_oe_b <= 1'b1;
      end else if (rd_go || (rd_run_q && link_edge)) begin
         if (rd_go || rd_beat_q != 4'h8) begin
            // Data and strobe change together, edge-aligned
            o_dq       <= rd_go ? rd_word_q[start_q*DQ_W +: DQ_W]
                                : rd_word_q[rd_pos*DQ_W +: DQ_W];
            o_dq_oe_b  <= 1'b0;
            o_dqs_oe_b <= 1'b0;
            o_dqs      <= rd_go ? 1'b1 : ~o_dqs;
            o_dqs_b    <= rd_go ? 1'b0 : ~o_dqs_b;
            rd_run_q   <= 1'b1;
            rd_beat_q  <= rd_go ? 4'h1 : rd_beat_q + 4'h1;
         end else begin
            rd_run_q   <= 1'b0;
            rd_beat_q  <= 4'h0;
            o_dq_oe_b  <= 1'b1;
            o_dqs_oe_b <= 1'b1;
            o_dqs      <= 1'b0;
            o_dqs_b    <= 1'b1;
         end
      end
   end

endmodule // ddr_dual_rank

/* design/ddr_dual_rank_defines.vh */
// Shared constants for the dual-rank memory device model
`ifndef DDR_DUAL_RANK_DEFINES_VH
`define DDR_DUAL_RANK_DEFINES_VH

// ****************************************
// Organisation
// ****************************************
`define DDR_RANKS          2
`define DDR_BANKS_PER_RANK 16
`define DDR_ROW_W          18
`define DDR_COL_W          10
`define DDR_BURST_LEN      8
`define DDR_BEAT_W         3

// ****************************************
// Link timing (figures at 3200 MT/s)
// ****************************************
`define DDR_TCK_PS         625
`define DDR_T_AA_PS        13750
`define DDR_T_RCD_PS       13750
`define DDR_T_RP_PS        13750
// Least times round up to whole link clocks
`define DDR_CYC(ps)        (((ps) + `DDR_TCK_PS - 1) / `DDR_TCK_PS)
`define DDR_RL_CK          `DDR_CYC(`DDR_T_AA_PS)
`define DDR_RCD_CK         `DDR_CYC(`DDR_T_RCD_PS)
`define DDR_RP_CK          `DDR_CYC(`DDR_T_RP_PS)
`define DDR_CNT_W          5

// ****************************************
// Command encodings {ras_b, cas_b, we_b}
// ****************************************
`define DDR_OP_PRE         3'h2
`define DDR_OP_REF         3'h1
`define DDR_OP_WR          3'h4
`define DDR_OP_RD          3'h5
`define DDR_PRE_ALL_BIT    10

`endif

/* verification/ddr_ctrl_model.sv */
// Memory controller model: link clock, commands and write bursts
`timescale 1ns/1ps
module ddr_ctrl_model (
   input  wire        i_clk,
   output reg         o_lk,
   output reg  [1:0]  o_cs_b,
   output reg         o_act_b,
   output reg  [2:0]  o_op,
   output reg  [3:0]  o_bank,
   output reg  [17:0] o_addr,
   output reg  [7:0]  o_dq,
   output reg         o_dqs
);
   initial begin
      {o_cs_b, o_act_b, o_op, o_bank, o_addr, o_dq, o_dqs} = {6'h3f, 31'h0};
      o_lk = 1'b1;
      #13;
      forever #160 o_lk = ~o_lk;
   end
   task cmd(input [1:0] cs, input act, input [2:0] op, input [3:0] bk, input [17:0] ad);
      begin
         @(negedge o_lk);
         @(posedge i_clk);
         o_cs_b  <= cs;
         o_act_b <= act;
         o_op    <= op;
         o_bank  <= bk;
         o_addr  <= ad;
         @(negedge o_lk);
         @(posedge i_clk);
         // Bank and address show the inverse; the op lines keep a stale copy
         o_cs_b  <= 2'h3;
         o_act_b <= 1'b1;
         o_bank  <= ~bk;
         o_addr  <= ~ad;
      end
   endtask
   task rises(input integer n);
      repeat (n) @(posedge o_lk);
   endtask
   task wr_burst(input [63:0] w);
      integer k;
      for (k = 0; k < 8; k = k + 1) begin
         @(posedge i_clk) o_dq <= w[k*8 +: 8];
         repeat (4) @(posedge i_clk);
         o_dqs <= ~o_dqs;
         repeat (4) @(posedge i_clk);
         o_dq <= ~o_dq;
      end
   endtask
endmodule // ddr_ctrl_model

/* verification/ddr_dual_rank_assertions.sv */
// Port-level checks for the dual-rank memory device
`timescale 1ns/1ps
module ddr_dual_rank_chk (
   input wire       i_clk,
   input wire       i_rst_b,
   input wire       i_link_clk,
   input wire [1:0] i_cs_b,
   input wire [1:0] i_cke,
   input wire [1:0] i_termination_control,
   input wire       i_act_b,
   input wire       i_ras_b,
   input wire       i_cas_b,
   input wire       i_we_b,
   input wire       o_dq_oe_b,
   input wire       o_dqs,
   input wire       o_dqs_b,
   input wire       o_dqs_oe_b,
   input wire [1:0] o_term_on,
   input wire       o_timing_err,
   input wire       o_protocol_err
);
   reg  [3:0] tog_q;
   reg        dqs_q;
   reg        lk_q;
   reg  [5:0] rl_q;
   wire       rise = i_link_clk & ~lk_q;
   wire       rd = rise & (^i_cs_b) & ((~i_cs_b & i_cke) != 2'h0) & i_act_b & i_ras_b
                   & ~i_cas_b & i_we_b;
   wire [1:0] treq = i_termination_control & i_cke;
   always @(posedge i_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         tog_q <= 4'h0;
         dqs_q <= 1'b0;
         lk_q  <= 1'b1;
         rl_q  <= 6'h00;
      end else begin
         dqs_q <= o_dqs;
         lk_q  <= i_link_clk;
         if (o_dqs_oe_b)
            tog_q <= 4'h0;
         else if (o_dqs != dqs_q)
            tog_q <= tog_q + 4'h1;
         // Saturate so a stale read never wraps back into range
         if (rd)
            rl_q <= 6'h01;
         else if (rise && rl_q != 6'h00 && rl_q != 6'h3f)
            rl_q <= rl_q + 6'h01;
      end
   end
   default clocking cb @(posedge i_clk); endclocking
   default disable iff (!i_rst_b);
   AST_OE_PAIR: assert property (o_dq_oe_b == o_dqs_oe_b)
      else $error("Enables differ");
   AST_DQS_DIFF: assert property (!o_dqs_oe_b |-> o_dqs != o_dqs_b)
      else $error("Strobe not differential");
   AST_TERM: assert property ($stable(treq)[*6] |-> o_term_on == treq)
      else $error("Termination wrong");
   AST_BURST_LEN: assert property ($rose(o_dqs_oe_b) |-> tog_q == 4'h8)
      else $error("Burst not eight beats");
   AST_READ_LAT: assert property ($fell(o_dqs_oe_b) |-> rl_q == 6'h17)
      else $error("Read latency wrong");
   AST_DRIVE_AFTER_RD: assert property (!o_dq_oe_b |-> rl_q >= 6'h17)
      else $error("Data driven without read");
   AST_BOTH_CS: assert property (rise && i_cs_b == 2'h0 |-> ##[1:6] o_protocol_err)
      else $error("Double select not flagged");
   AST_TERR_PULSE: assert property (o_timing_err |=> !o_timing_err)
      else $error("Timing flag too long");
   cover property ($fell(o_dqs_oe_b));
   cover property (o_timing_err);
   cover property (o_protocol_err);
endmodule // ddr_dual_rank_chk

bind ddr_dual_rank ddr_dual_rank_chk u_ddr_dual_rank_chk (.*);

/* verification/tb_top.sv */
// Self-checking bench for the dual-rank memory device
`timescale 1ns/1ps
`include "ddr_dual_rank_defines.vh"
`define CHK(a, b) begin tests_run = tests_run + 1; if ((a) !== (b)) begin \
   num_errors = num_errors + 1; $display("[ERR] %0t got %h want %h", $time, a, b); end end
module tb_top;
   reg         clk = 1'b0;
   reg         rst_b = 1'b0;
   reg  [1:0]  cke = 2'h3;
   reg  [1:0]  term = 2'h0;
   reg         narrow = 1'b0;
   reg         ilv = 1'b0;
   wire        lk, act_b, dqs_w, dq_oe_b, dqs_r, dqs_b_r, dqs_oe_b, terr, perr;
   wire [1:0]  cs_b, term_on;
   wire [2:0]  op;
   wire [3:0]  bk;
   wire [17:0] addr;
   wire [7:0]  dq_w, dq_r;
   integer     num_errors = 0, tests_run = 0, terr_n = 0, perr_n = 0, drv_n = 0, it, snap;
   reg  [15:0] rnd = 16'h0010;
   reg  [63:0] w0, w1;
   reg  [9:0]  c1, c2;
   always #20 clk = ~clk;
   ddr_dual_rank u_ddr_dual_rank (.i_clk(clk), .i_rst_b(rst_b), .i_link_clk(lk),
      .i_cs_b(cs_b), .i_cke(cke), .i_termination_control(term), .i_act_b(act_b),
      .i_ras_b(op[2]), .i_cas_b(op[1]), .i_we_b(op[0]), .i_bank_group_field(bk[3:2]),
      .i_bank_field(bk[1:0]), .i_addr(addr), .i_narrow_cfg(narrow), .i_burst_interleave(ilv),
      .i_dq(dq_w), .i_dqs(dqs_w), .o_dq(dq_r), .o_dq_oe_b(dq_oe_b), .o_dqs(dqs_r),
      .o_dqs_b(dqs_b_r), .o_dqs_oe_b(dqs_oe_b), .o_term_on(term_on), .o_timing_err(terr),
      .o_protocol_err(perr));
   ddr_ctrl_model u_ddr_ctrl_model (.i_clk(clk), .o_lk(lk), .o_cs_b(cs_b), .o_act_b(act_b),
      .o_op(op), .o_bank(bk), .o_addr(addr), .o_dq(dq_w), .o_dqs(dqs_w));
   always @(posedge clk) begin
      terr_n = terr_n + (terr === 1'b1);
      perr_n = perr_n + (perr === 1'b1);
      drv_n  = drv_n + (dq_oe_b === 1'b0);
   end
   // ****************************************
   // Expectation helpers
   // ****************************************
   function [15:0] lfsr(input [15:0] s);
      lfsr = {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
   endfunction
   function [2:0] pos(input [2:0] s, input i, input [2:0] k);
      pos = i ? (s ^ k) : (s + k);
   endfunction
   function [63:0] reorder(input [63:0] w, input [2:0] s1, input [2:0] s2, input i);
      reg [7:0] m [0:7];
      integer k;
      begin
         for (k = 0; k < 8; k = k + 1)
            m[pos(s1, i, k)] = w[k*8 +: 8];
         for (k = 0; k < 8; k = k + 1)
            reorder[k*8 +: 8] = m[pos(s2, i, k)];
      end
   endfunction
   task get64(output [63:0] v);
      integer k;
      for (k = 0; k < 4; k = k + 1) begin
         rnd = lfsr(rnd);
         v = {v[47:0], rnd};
      end
   endtask
   task rd_check(input [63:0] e);
      integer k, j;
      reg d;
      begin
         j = 0;
         while (dq_oe_b !== 1'b0 && j < 400) begin
            @(posedge clk) #1;
            j = j + 1;
         end
         for (k = 0; k < 8; k = k + 1) begin
            `CHK(dq_r, e[k*8 +: 8])
            d = dqs_r;
            j = 0;
            while (k < 7 && dqs_r === d && j < 20) begin
               @(posedge clk) #1;
               j = j + 1;
            end
         end
         repeat (8) @(posedge clk);
         `CHK({dq_oe_b, dqs_oe_b}, 2'h3)
      end
   endtask
   task complete_run;
      begin
         $display("tests_run=%0d num_errors=%0d", tests_run, num_errors);
         if (num_errors == 0 && tests_run > 0)
            $display("== PASSED ==");
         else
            $display("== FAILED ==");
         $finish;
      end
   endtask
   initial begin
      #2_000_000;
      num_errors = num_errors + 1;
      complete_run;
   end
   initial begin
      repeat (5) @(posedge clk);
      rst_b <= 1'b1;
      @(posedge clk) #1;
      `CHK({dq_oe_b, dqs_r, dqs_b_r, term_on}, 5'h14)
      @(posedge clk) term <= 2'h3;
      cke <= 2'h1;
      repeat (6) @(posedge clk) #1;
      `CHK(term_on, 2'h1)
      @(posedge clk) term <= 2'h2;
      cke <= 2'h3;
      repeat (6) @(posedge clk) #1;
      `CHK(term_on, 2'h2)
      $display("test termination done");
      u_ddr_ctrl_model.rises(3);
      for (it = 0; it < 4; it = it + 1) begin
         @(posedge clk) narrow <= it[1];
         ilv <= it[0];
         get64(w0);
         get64(w1);
         c1 = w1[9:0];
         c2 = {c1[9:3], w1[12:10]};
         u_ddr_ctrl_model.cmd(2'h2, 1'b0, 3'h7, w0[3:0], w0[17:0]);
         u_ddr_ctrl_model.cmd(2'h1, 1'b0, 3'h7, w0[3:0], w1[17:0]);
         u_ddr_ctrl_model.rises(22);
         u_ddr_ctrl_model.cmd(2'h2, 1'b1, `DDR_OP_WR, w0[3:0], {8'h00, c1});
         u_ddr_ctrl_model.wr_burst(w0);
         u_ddr_ctrl_model.cmd(2'h1, 1'b1, `DDR_OP_WR, w0[3:0], {8'h00, c1});
         u_ddr_ctrl_model.wr_burst(w1);
         u_ddr_ctrl_model.cmd(2'h2, 1'b1, `DDR_OP_RD, w0[3:0], {8'h00, c2});
         rd_check(reorder(w0, c1[2:0], c2[2:0], it[0]));
         u_ddr_ctrl_model.cmd(2'h1, 1'b1, `DDR_OP_RD, w0[3:0], {8'h00, c2});
         rd_check(reorder(w1, c1[2:0], c2[2:0], it[0]));
         u_ddr_ctrl_model.cmd(2'h2, 1'b1, `DDR_OP_PRE, w0[3:0], 18'h00000);
         u_ddr_ctrl_model.cmd(2'h1, 1'b1, `DDR_OP_PRE, w0[3:0], 18'h00400);
         u_ddr_ctrl_model.rises(22);
         u_ddr_ctrl_model.cmd(2'h2, 1'b1, `DDR_OP_REF, 4'h0, 18'h0);
         u_ddr_ctrl_model.cmd(2'h1, 1'b1, `DDR_OP_REF, 4'h0, 18'h0);
         $display("test burst %0d done", it);
      end
      `CHK(terr_n + perr_n, 0)
      u_ddr_ctrl_model.cmd(2'h2, 1'b0, 3'h7, 4'h0, 18'h0);
      u_ddr_ctrl_model.rises(5);
      u_ddr_ctrl_model.cmd(2'h2, 1'b1, `DDR_OP_RD, 4'h0, 18'h0);
      u_ddr_ctrl_model.rises(40);
      `CHK(terr_n, 1)
      u_ddr_ctrl_model.cmd(2'h2, 1'b0, 3'h7, 4'h0, 18'h1);
      snap = drv_n;
      u_ddr_ctrl_model.cmd(2'h1, 1'b1, `DDR_OP_RD, 4'h5, 18'h0);
      u_ddr_ctrl_model.cmd(2'h0, 1'b1, `DDR_OP_RD, 4'h0, 18'h0);
      u_ddr_ctrl_model.rises(40);
      `CHK(perr_n, 3)
      `CHK(drv_n, snap)
      $display("test errors done");
      complete_run;
   end
endmodule // tb_top
